/* File: logic/tiwa_pkg.sv */
package tiwa_pkg;
    // ****************************************************************
    // word and block geometry
    // ****************************************************************
    localparam int DIGIT_W        = 7;   // pulses per sensed digit
    localparam int DIGITS_PER_WORD = 12;
    localparam int WORDS_PER_BLOCK = 60;
    localparam int DRIVE_W        = 4;   // selector digit width
    localparam int NUM_DRIVES     = 16;
    localparam int ADDR_W         = 10;
    // ****************************************************************
    // order codes (first instruction digit)
    // ****************************************************************
    localparam logic [3:0] OP_READ_FWD  = 4'h1;
    localparam logic [3:0] OP_READ_BWD  = 4'h2;
    localparam logic [3:0] OP_MOVE_A    = 4'h3;
    localparam logic [3:0] OP_MOVE_B    = 4'h4;
    localparam logic [3:0] OP_WRITE_A   = 4'h5;
    localparam logic [3:0] OP_WRITE_B   = 4'h7;
    localparam logic [3:0] OP_REWIND    = 4'h8;
    // ****************************************************************
    // stall indication values
    // ****************************************************************
    localparam logic [3:0] STALL_PC     = 4'h0;   // program counter 0000
    localparam logic [1:0] STALL_CC     = 2'h3;   // cycle counter 11
    localparam logic [3:0] PC_RESET     = 4'h0;
    localparam logic [1:0] CC_RESET     = 2'h0;
endpackage

/* File: logic/tiwa_skid.sv */
`timescale 1ns/1ps
// two-entry buffer between the assembly buffers and the block store
module tiwa_skid #(
    parameter int W = 84
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    tiwa_word_if.dst  in_if,
    tiwa_word_if.src  out_if
);
    logic [W-1:0] mem_reg [2];
    logic         wr_ptr_reg;
    logic         rd_ptr_reg;
    logic [1:0]   count_reg;
    wire          push = in_if.valid && in_if.ready;
    wire          pop  = out_if.valid && out_if.ready;

    // full and empty from the entry count
    assign in_if.ready  = (count_reg != 2'h2);
    assign out_if.valid = (count_reg != 2'h0);
    assign out_if.data  = mem_reg[rd_ptr_reg];

    // pointer and count update
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) mem_reg[wr_ptr_reg] <= in_if.data;
    end
endmodule // tiwa_skid

/* File: logic/tiwa_top.sv */
`timescale 1ns/1ps
module tiwa_top #(
    parameter int DIGIT_W = tiwa_pkg::DIGIT_W,
    parameter int NDIG    = tiwa_pkg::DIGITS_PER_WORD,
    parameter int NWORD   = tiwa_pkg::WORDS_PER_BLOCK,
    parameter int NDRV    = tiwa_pkg::NUM_DRIVES
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          digit_valid,
    input  wire logic [DIGIT_W-1:0]            digit_data,
    input  wire logic                          order_valid,
    input  wire logic [3:0]                    order_op,
    input  wire logic [tiwa_pkg::DRIVE_W-1:0]  order_drive,
    input  wire logic [tiwa_pkg::ADDR_W-1:0]   order_addr,
    input  wire logic                          error_clear,
    input  wire logic                          store_clear,
    input  wire logic                          start_bar,
    input  wire logic                          move_ready,
    output logic                               read_active,
    output logic                               read_forward,
    output logic [tiwa_pkg::DRIVE_W-1:0]       read_drive,
    output logic                               block_done,
    output logic [1:0]                         input_parity_error,
    output logic                               timeout_lamp,
    output logic                               stall,
    output logic [3:0]                         program_counter,
    output logic [1:0]                         cycle_counter,
    output logic [tiwa_pkg::DRIVE_W+4+tiwa_pkg::ADDR_W-1:0] static_order,
    output logic [NDRV-1:0]                    drive_read_lamp,
    output logic [NDRV-1:0]                    drive_fwd_lamp,
    output logic                               move_valid,
    output logic [tiwa_pkg::ADDR_W-1:0]        move_addr,
    output logic [DIGIT_W*NDIG-1:0]            move_word
);
    localparam int WW  = DIGIT_W * NDIG;
    localparam int DCW = $clog2(NDIG);
    localparam int WCW = $clog2(NWORD + 1);
    localparam int SOW = tiwa_pkg::DRIVE_W + 4 + tiwa_pkg::ADDR_W;

    // ****************************************************************
    // order decode
    // ****************************************************************
    typedef enum logic [1:0] {
        TIWA_IDLE  = 2'b00,
        TIWA_READ  = 2'b01,
        TIWA_MOVE  = 2'b11,
        TIWA_STALL = 2'b10
    } tiwa_state_t;

    tiwa_state_t state_reg;
    tiwa_state_t state_next;

    wire is_read   = (order_op == tiwa_pkg::OP_READ_FWD) ||
                     (order_op == tiwa_pkg::OP_READ_BWD);
    wire is_move   = (order_op == tiwa_pkg::OP_MOVE_A) ||
                     (order_op == tiwa_pkg::OP_MOVE_B) ||
                     (order_op == 4'h0);
    wire is_wr_rw  = (order_op == tiwa_pkg::OP_WRITE_A) ||
                     (order_op == tiwa_pkg::OP_WRITE_B) ||
                     (order_op == tiwa_pkg::OP_REWIND);
    wire [NDRV-1:0] drv_sel = NDRV'(1) << order_drive;
    wire            any_err;
    wire            drv_err;
    wire            stall_hit;

    // ****************************************************************
    // parity checkers and per-drive error latches
    // ****************************************************************
    logic [1:0]      chk_fail;
    logic [NDRV-1:0] drv_err_reg;
    logic [1:0]      ip_err_reg;

    // two independent odd-pulse checkers
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chk
            assign chk_fail[g] = digit_valid && read_active &&
                                 !(^digit_data);
        end
    endgenerate

    assign any_err   = |drv_err_reg;
    assign drv_err   = |(drv_err_reg & drv_sel);
    assign stall_hit = order_valid && any_err &&
                       (is_read || (is_wr_rw && drv_err));

    // error latches: set wins over clear; start has no effect here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drv_err_reg <= '0;
            ip_err_reg  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++)
                ip_err_reg[i] <= chk_fail[i] | (ip_err_reg[i] & ~error_clear);
            for (int d = 0; d < NDRV; d++)
                drv_err_reg[d] <= ((|chk_fail) && (read_drive == d)) |
                                  (drv_err_reg[d] & ~error_clear);
        end
    end

    // ****************************************************************
    // word assembly buffers
    // ****************************************************************
    logic [WW-1:0]   wab_reg [2];
    logic            fill_sel_reg;
    logic [DCW-1:0]  dig_cnt_reg;
    logic [WCW-1:0]  word_cnt_reg;
    logic            pend_reg;
    logic [WW-1:0]   pend_word_reg;

    tiwa_word_if #(.W(WW)) wab_if ();
    tiwa_word_if #(.W(WW)) ibs_if ();

    wire digit_take = digit_valid && read_active;
    wire word_end   = digit_take && (dig_cnt_reg == DCW'(NDIG - 1));
    wire [WW-1:0] word_full = {wab_reg[fill_sel_reg][WW-DIGIT_W-1:0], digit_data};

    assign wab_if.valid = pend_reg;
    assign wab_if.data  = pend_word_reg;

    // digit shift into the filling buffer, swap after twelve
    always_ff @(posedge clk_sys) begin
        if (rst || !read_active) begin
            fill_sel_reg <= 1'b0;
            dig_cnt_reg  <= '0;
        end else if (digit_take) begin
            wab_reg[fill_sel_reg] <= word_full;
            dig_cnt_reg  <= word_end ? '0 : dig_cnt_reg + DCW'(1);
            if (word_end) fill_sel_reg <= ~fill_sel_reg;
        end
    end

    // unload of the idle buffer toward the block store
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_reg      <= 1'b0;
            pend_word_reg <= '0;
        end else if (word_end) begin
            pend_reg      <= 1'b1;
            pend_word_reg <= word_full;
        end else if (wab_if.ready) begin
            pend_reg <= 1'b0;
        end
    end

    tiwa_skid #(.W(WW)) u_skid (
        .clk_sys (clk_sys),
        .rst     (rst),
        .in_if   (wab_if),
        .out_if  (ibs_if)
    );

    // ****************************************************************
    // input block store
    // ****************************************************************
    logic [WW-1:0]  ibs_mem [NWORD];
    logic [WCW-1:0] ibs_wr_reg;
    logic [WCW-1:0] mv_idx_reg;
    logic [WCW-1:0] ibs_fill_reg;

    assign ibs_if.ready = (ibs_wr_reg < WCW'(NWORD));
    wire ibs_push = ibs_if.valid && ibs_if.ready;
    wire mv_fire  = (state_reg == TIWA_MOVE) && (!move_valid || move_ready);
    wire mv_last  = mv_idx_reg == ibs_fill_reg;

    // store write port; clear erases every word
    always_ff @(posedge clk_sys) begin
        if (rst || store_clear) begin
            ibs_wr_reg <= '0;
            for (int k = 0; k < NWORD; k++) ibs_mem[k] <= '0;
        end else if (ibs_push) begin
            ibs_mem[ibs_wr_reg] <= ibs_if.data;
            ibs_wr_reg <= ibs_wr_reg + WCW'(1);
        end
    end

    // words read from tape this block
    always_ff @(posedge clk_sys) begin
        if (rst || (state_reg == TIWA_IDLE)) word_cnt_reg <= '0;
        else if (word_end) word_cnt_reg <= word_cnt_reg + WCW'(1);
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    wire blk_end = word_end && (word_cnt_reg == WCW'(NWORD - 1));

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TIWA_IDLE:
                if (stall_hit) state_next = TIWA_STALL;
                else if (order_valid && is_read) state_next = TIWA_READ;
                else if (order_valid && is_move) state_next = TIWA_MOVE;
            TIWA_READ:  if (blk_end) state_next = TIWA_IDLE;
            TIWA_MOVE:  if (mv_fire && mv_last) state_next = TIWA_IDLE;
            TIWA_STALL: if (!any_err) state_next = TIWA_IDLE;
            default:    state_next = TIWA_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) state_reg <= TIWA_IDLE;
        else state_reg <= state_next;
    end

    // read control, drive select and direction
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_active  <= 1'b0;
            read_forward <= 1'b0;
            read_drive   <= '0;
            block_done   <= 1'b0;
        end else begin
            block_done <= blk_end;
            if (state_reg == TIWA_IDLE && state_next == TIWA_READ) begin
                read_active  <= 1'b1;
                read_drive   <= order_drive;
                read_forward <= (order_op == tiwa_pkg::OP_READ_FWD);
            end else if (blk_end) begin
                read_active <= 1'b0;
            end
        end
    end

    // lamps of the drive that failed, read lamp off on error clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive_read_lamp <= '0;
            drive_fwd_lamp  <= '0;
        end else begin
            for (int d = 0; d < NDRV; d++) begin
                if ((|chk_fail) && (read_drive == d)) begin
                    drive_read_lamp[d] <= 1'b1;
                    drive_fwd_lamp[d]  <= read_forward;
                end else if (error_clear) begin
                    drive_read_lamp[d] <= 1'b0;
                end
            end
        end
    end

    // move of the block store to sixty consecutive locations
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mv_idx_reg   <= '0;
            ibs_fill_reg <= '0;
            move_valid   <= 1'b0;
            move_addr    <= '0;
            move_word    <= '0;
        end else if (state_reg == TIWA_IDLE && state_next == TIWA_MOVE) begin
            mv_idx_reg   <= '0;
            ibs_fill_reg <= WCW'(NWORD - 1);
            move_addr    <= order_addr;
            move_valid   <= 1'b0;
        end else if (mv_fire) begin
            move_valid <= 1'b1;
            move_word  <= ibs_mem[mv_idx_reg[WCW-1:0]];
            if (move_valid) move_addr <= move_addr + tiwa_pkg::ADDR_W'(1);
            mv_idx_reg <= mv_idx_reg + WCW'(1);
        end else if (move_ready) begin
            move_valid <= 1'b0;
        end
    end

    // stall indications and static order register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            input_parity_error <= 2'h0;
            timeout_lamp       <= 1'b0;
            stall              <= 1'b0;
            program_counter    <= tiwa_pkg::PC_RESET;
            cycle_counter      <= tiwa_pkg::CC_RESET;
            static_order       <= '0;
        end else begin
            input_parity_error <= ip_err_reg;
            timeout_lamp       <= 1'b0;
            stall              <= (state_next == TIWA_STALL);
            if (stall_hit && state_reg == TIWA_IDLE) begin
                program_counter <= tiwa_pkg::STALL_PC;
                cycle_counter   <= tiwa_pkg::STALL_CC;
            end
            if (order_valid && state_reg == TIWA_IDLE && !start_bar)
                static_order <= SOW'({order_op, order_drive, order_addr});
        end
    end
endmodule // tiwa_top

/* File: logic/tiwa_word_if.sv */
`timescale 1ns/1ps
interface tiwa_word_if #(parameter int W = 84);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
// ****************************************
// bench for the tape input block
// ****************************************
module tb_top;
    logic        clk_sys, rst, digit_valid, order_valid, error_clear, store_clear;
    logic        start_bar, move_ready, read_active, read_forward, block_done;
    logic        timeout_lamp, stall, move_valid;
    logic [1:0]  input_parity_error, cycle_counter;
    logic [3:0]  order_op, order_drive, read_drive, program_counter;
    logic [9:0]  order_addr, move_addr;
    logic [6:0]  digit_data;
    logic [15:0] bad_idx, drive_read_lamp, drive_fwd_lamp;
    logic [17:0] static_order;
    logic [83:0] move_word;
    logic [6:0]  dq[$];
    logic [83:0] wq[$];
    int          err_total = 0;
    int          tests_run = 0;
    integer      seed = 89;
    tiwa_top i_dut (
        .clk_sys(clk_sys), .rst(rst), .digit_valid(digit_valid), .digit_data(digit_data),
        .order_valid(order_valid), .order_op(order_op), .order_drive(order_drive),
        .order_addr(order_addr), .error_clear(error_clear), .store_clear(store_clear),
        .start_bar(start_bar), .move_ready(move_ready), .read_active(read_active),
        .read_forward(read_forward), .read_drive(read_drive), .block_done(block_done),
        .input_parity_error(input_parity_error), .timeout_lamp(timeout_lamp), .stall(stall),
        .program_counter(program_counter), .cycle_counter(cycle_counter),
        .static_order(static_order), .drive_read_lamp(drive_read_lamp),
        .drive_fwd_lamp(drive_fwd_lamp), .move_valid(move_valid), .move_addr(move_addr),
        .move_word(move_word));
    tiwa_tape_model u_tape (.clk_sys(clk_sys), .read_active(read_active),
        .bad_idx(bad_idx), .digit_valid(digit_valid), .digit_data(digit_data));
    // clock and digit capture
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (digit_valid && read_active) dq.push_back(digit_data);
    // consumer stalls at random
    always @(negedge clk_sys) move_ready <= ($random(seed) & 3) != 0;
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic send_order(input logic [3:0] op, input logic [3:0] drv,
                              input logic [9:0] adr);
        @(negedge clk_sys);
        {order_valid, order_op, order_drive, order_addr} = {1'b1, op, drv, adr};
        @(negedge clk_sys);
        order_valid = 1'b0;
    endtask
    task automatic do_read(input logic [3:0] op, input logic [3:0] drv, input logic [15:0] bad);
        int k;
        @(negedge clk_sys);
        store_clear = 1'b1; // drop any earlier block first
        @(negedge clk_sys);
        store_clear = 1'b0;
        bad_idx = bad;
        dq.delete();
        send_order(op, drv, 10'h000);
        `CHK(read_active, 1'b1)
        `CHK(read_forward, op == tiwa_pkg::OP_READ_FWD)
        `CHK(read_drive, drv)
        for (k = 0; block_done !== 1'b1 && k < 4000; k++) @(negedge clk_sys);
        `CHK(dq.size(), 720)
        @(negedge clk_sys);
        `CHK(read_active, 1'b0)
    endtask
    // watchdog
    initial begin
        #2000000;
        err_total++;
        report_and_stop();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int          i, k, n;
        logic [3:0]  op, d2;
        logic [9:0]  m;
        logic [83:0] w;
        {rst, order_valid, error_clear, store_clear, start_bar} = 5'h10;
        {order_op, order_drive, order_addr, bad_idx} = '0;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        `CHK({stall, read_active, move_valid, input_parity_error}, 5'h00)
        $display("reset test done");
        // bad digit, then the order that must stall
        for (i = 0; i < 2; i++) begin
            d2 = i ? 4'h1 : 4'h2;
            do_read(i ? tiwa_pkg::OP_READ_FWD : tiwa_pkg::OP_READ_BWD, d2, 16'(100 + 500 * i));
            `CHK(input_parity_error, 2'h3)
            `CHK(stall, 1'b0)
            `CHK({drive_read_lamp[d2], drive_fwd_lamp[d2]}, {1'b1, i[0]})
            @(negedge clk_sys);
            start_bar = 1'b1;
            @(negedge clk_sys);
            start_bar = 1'b0;
            `CHK(input_parity_error, 2'h3)
            send_order(tiwa_pkg::OP_WRITE_A, d2 + 4'h1, 10'h000);
            `CHK(stall, 1'b0)
            op = i ? tiwa_pkg::OP_READ_FWD : tiwa_pkg::OP_REWIND;
            d2 = i ? 4'h4 : 4'h2;
            m = 10'($random(seed));
            send_order(op, d2, m);
            `CHK({stall, timeout_lamp, program_counter, cycle_counter}, 8'h83)
            `CHK(static_order, {op, d2, m})
            error_clear = 1'b1;
            @(negedge clk_sys);
            error_clear = 1'b0;
            @(negedge clk_sys);
            `CHK({stall, input_parity_error, drive_read_lamp}, 19'h0)
        end
        $display("parity stall test done");
        // clean block moved to memory, both read forms and the OP_MOVE_A and OP_MOVE_B move forms
        for (i = 0; i < 2; i++) begin
            do_read(i ? tiwa_pkg::OP_READ_BWD : tiwa_pkg::OP_READ_FWD, 4'(i + 3), 16'hFFFF);
            `CHK(input_parity_error, 2'h0)
            wq.delete();
            for (n = 0; n < 720; n++) begin
                w = {w[76:0], dq[n]};
                if (n % 12 == 11) wq.push_back(w);
            end
            m = 10'($random(seed));
            send_order(i ? tiwa_pkg::OP_MOVE_B : tiwa_pkg::OP_MOVE_A, 4'(i * 5), m);
            for (n = 0; n < 60; n++) begin
                k = 0;
                do begin
                    @(negedge clk_sys);
                    #1;
                    k++;
                end while (!(move_valid === 1'b1 && move_ready) && k < 200);
                `CHK(move_addr, m + 10'(n))
                `CHK(move_word, wq[n])
            end
        end
        $display("block move test done");
        report_and_stop();
    end
endmodule // tb_top

/* File: verification/tiwa_tape_model.sv */
`timescale 1ns/1ps
// ****************************************
// tape drive sending one block of digits
// ****************************************
module tiwa_tape_model (
    input  wire logic        clk_sys,
    input  wire logic        read_active,
    input  wire logic [15:0] bad_idx,
    output logic             digit_valid,
    output logic [6:0]       digit_data
);
    integer     seed = 89;
    integer     sent = 0;
    logic [6:0] d;
    initial digit_valid = 1'b0;
    initial digit_data = 7'h55;
    // random gaps; digit number bad_idx gets even pulse count
    always @(negedge clk_sys) begin
        d = 7'($random(seed));
        if (read_active && sent < 720 && ($random(seed) & 3) != 0) begin
            if ((^d) == (sent == bad_idx)) d[0] = ~d[0];
            digit_valid <= 1'b1;
            digit_data <= d;
            sent <= sent + 1;
        end else begin
            digit_valid <= 1'b0;
            digit_data <= ~digit_data; // no stale digit between digits
            if (!read_active) sent <= 0;
        end
    end
endmodule // tiwa_tape_model

/* File: verification/tiwa_top_sva.sv */
`timescale 1ns/1ps
// ****************************************
// port checker for the tape input block
// ****************************************
module tiwa_top_sva #(
    parameter int NDRV = 16
) (
    input wire logic            clk_sys,
    input wire logic            rst,
    input wire logic            order_valid,
    input wire logic [3:0]      order_op,
    input wire logic [3:0]      order_drive,
    input wire logic [9:0]      order_addr,
    input wire logic            error_clear,
    input wire logic            move_ready,
    input wire logic            read_active,
    input wire logic            read_forward,
    input wire logic [3:0]      read_drive,
    input wire logic [1:0]      input_parity_error,
    input wire logic            stall,
    input wire logic [3:0]      program_counter,
    input wire logic [1:0]      cycle_counter,
    input wire logic [17:0]     static_order,
    input wire logic [NDRV-1:0] drive_read_lamp,
    input wire logic            move_valid,
    input wire logic [9:0]      move_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // stall display, the order held, parity copies and error clear
    property p_stall_show;
        stall |-> program_counter == 4'h0 && cycle_counter == 2'h3;
    endproperty
    a_stall_show: assert property (p_stall_show) else $error("stall display wrong");
    property p_stall_order;
        $rose(stall) |-> static_order == {$past(order_op), $past(order_drive), $past(order_addr)};
    endproperty
    a_stall_order: assert property (p_stall_order) else $error("stalled order lost");
    property p_twin;
        input_parity_error[0] == input_parity_error[1];
    endproperty
    a_twin: assert property (p_twin) else $error("parity copies disagree");
    property p_clear;
        error_clear && !read_active && !$past(read_active)
            |=> ##1 input_parity_error == 2'h0 && drive_read_lamp == '0 && !stall;
    endproperty
    a_clear: assert property (p_clear) else $error("error clear ignored");
    // read start, drive and direction
    property p_read_drive;
        $rose(read_active) |-> $past(order_valid) && read_drive == $past(order_drive);
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("wrong drive read");
    property p_read_dir;
        $rose(read_active) |-> read_forward == ($past(order_op) == 4'h1);
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("wrong direction");
    // transfers to memory
    property p_move_hold;
        move_valid && !move_ready |=> move_valid && $stable(move_addr);
    endproperty
    a_move_hold: assert property (p_move_hold) else $error("stalled word dropped");
    property p_move_step;
        move_valid && move_ready |=> !move_valid || move_addr == $past(move_addr) + 10'h001;
    endproperty
    a_move_step: assert property (p_move_step) else $error("address not stepped");
endmodule // tiwa_top_sva

bind tiwa_top tiwa_top_sva #(.NDRV(NDRV)) i_sva (
    .clk_sys(clk_sys), .rst(rst), .order_valid(order_valid), .order_op(order_op),
    .order_drive(order_drive), .order_addr(order_addr), .error_clear(error_clear),
    .move_ready(move_ready), .read_active(read_active), .read_forward(read_forward),
    .read_drive(read_drive), .input_parity_error(input_parity_error), .stall(stall),
    .program_counter(program_counter), .cycle_counter(cycle_counter),
    .static_order(static_order), .drive_read_lamp(drive_read_lamp),
    .move_valid(move_valid), .move_addr(move_addr)
);
